// ===== logic/idata_sfr_regs.vh
`ifndef IDATA_SFR_REGS_VH
`define IDATA_SFR_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// special function register addresses
`define ADDR_PORT_ZERO_LATCH 8'h80
`define ADDR_STACK_TOP_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW_BYTE 8'h82
`define ADDR_DATA_POINTER_HIGH_BYTE 8'h83
`define ADDR_TIMER0_COUNT_LOW 8'h8a
`define ADDR_TIMER1_COUNT_LOW 8'h8b
`define ADDR_TIMER0_COUNT_HIGH 8'h8c
`define ADDR_TIMER1_COUNT_HIGH 8'h8d
`define ADDR_PORT_ONE_LATCH 8'h90
`define ADDR_SERIAL_BUFFER 8'h99
`define ADDR_PORT_TWO_LATCH 8'ha0
`define ADDR_INTERRUPT_ENABLE_MASK 8'ha8
`define ADDR_PORT_THREE_LATCH 8'hb0
`define ADDR_INTERRUPT_PRIORITY_SELECT 8'hb8
`define ADDR_CAPTURE_HIGH_REGISTER 8'hca
`define ADDR_CAPTURE_LOW_REGISTER 8'hcb
`define ADDR_TIMER2_COUNT_LOW 8'hcc
`define ADDR_TIMER2_COUNT_HIGH 8'hcd
`define ADDR_STATUS_WORD 8'hd0
`define ADDR_MAIN_OPERAND_REGISTER 8'he0
`define ADDR_MULTIPLY_DIVIDE_AUX_REGISTER 8'hf0

////////////////////////////////////////////////////////////////////////////////
// reset values, and the value read from unimplemented addresses
`define RST_PORT_LATCH 8'hff
`define RST_STACK_TOP_POINTER 8'h07
`define RST_ZERO_BYTE 8'h00
`define RST_INTERRUPT_ENABLE_MASK 8'h00
`define RST_INTERRUPT_PRIORITY_SELECT 8'h00
`define UNIMPLEMENTED_READ 8'h00

////////////////////////////////////////////////////////////////////////////////
// fields and spaces
`define STATUS_BANK_LOW_BIT 3
`define STATUS_BANK_HIGH_BIT 4
`define BIT_AREA_BASE_NIBBLE 4'h2
`define ONCHIP_CODE_BYTES 16'h2000
`define TIMER_COUNT_MAX 16'hffff

////////////////////////////////////////////////////////////////////////////////
// command codes of the core access port
`define CMD_DIRECT 3'h0
`define CMD_INDIRECT 3'h1
`define CMD_BIT 3'h2
`define CMD_WORKING_REG 3'h3
`define CMD_STACK_SAVE 3'h4
`define CMD_STACK_RESTORE 3'h5

`endif

// ===== logic/idata_ram.v
`timescale 1ns/100ps
// single port data ram, registered read
module idata_ram #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire clock,
  input wire we,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q
);

  reg [7:0] mem_q [0:DEPTH-1];

  // no reset on the array: contents are undefined after power-up
  always @(posedge clock) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata_q <= mem_q[addr];
  end

endmodule // idata_ram

// ===== logic/idata_sfr_map.v
`timescale 1ns/100ps
`include "idata_sfr_regs.vh"

module idata_sfr_map #(
  parameter HAS_ONCHIP_CODE = 1'b1
) (
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire cmd_write,
  input wire [7:0] cmd_addr,
  input wire [7:0] cmd_wdata,
  output wire cmd_ready,
  output wire rd_valid,
  output wire [7:0] rd_data,
  input wire md_we,
  input wire [7:0] md_main_wdata,
  input wire [7:0] md_aux_wdata,
  input wire data_pointer_we,
  input wire [15:0] data_pointer_wdata,
  input wire [15:0] prog_addr,
  output wire code_onchip,
  input wire [2:0] timer_tick,
  input wire t2_capture_mode,
  input wire t2_reload_mode,
  input wire timer2_external_trigger_pin,
  input wire rx_load,
  input wire [7:0] rx_data,
  output wire [7:0] tx_data,
  output wire tx_start,
  output wire [7:0] main_operand,
  output wire [7:0] aux_operand,
  output wire [15:0] data_pointer,
  output wire [7:0] stack_top_pointer,
  output wire [1:0] bank_select,
  output wire [7:0] port_zero_latch,
  output wire [7:0] port_one_latch,
  output wire [7:0] port_two_latch,
  output wire [7:0] port_three_latch,
  output wire [7:0] interrupt_enable_mask,
  output wire [7:0] interrupt_priority_select,
  output wire [15:0] timer0_count,
  output wire [15:0] timer1_count,
  output wire [15:0] timer2_count,
  output wire [15:0] capture_value
);

  localparam S_IDLE = 1'b0;
  localparam S_READ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function [7:0] bit_to_byte;
    input [7:0] a;
    begin
      if (a[7]) begin
        bit_to_byte = {a[7:3], 3'b000};
      end else begin
        bit_to_byte = {`BIT_AREA_BASE_NIBBLE, a[6:3]};
      end
    end
  endfunction

  function [7:0] working_addr;
    input [1:0] bank;
    input [2:0] num;
    begin
      working_addr = {3'b000, bank, num};
    end
  endfunction

  function [7:0] put_bit;
    input [7:0] b;
    input [2:0] sel;
    input v;
    reg [7:0] r;
    begin
      r = b;
      r[sel] = v;
      put_bit = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state
  reg state_q, state_d;
  reg cmd_ready_q;
  reg rd_valid_q;
  reg [7:0] rd_data_q;
  reg from_ram_q;
  reg bit_mode_q;
  reg bit_write_q;
  reg bit_val_q;
  reg [2:0] bit_sel_q;
  reg [7:0] hold_addr_q;
  reg [7:0] pend_q;
  reg code_onchip_q;
  reg tx_start_q;
  reg [7:0] tx_data_q;
  reg [7:0] rx_buffer_q;
  reg [7:0] main_q;
  reg [7:0] aux_q;
  reg [7:0] ptr_lo_q;
  reg [7:0] ptr_hi_q;
  reg [7:0] stack_q;
  reg [7:0] status_q;
  reg [7:0] port_q [0:3];
  reg [7:0] irq_en_q;
  reg [7:0] irq_pri_q;
  reg [15:0] count_q [0:2];
  reg [7:0] cap_hi_q;
  reg [7:0] cap_lo_q;
  reg trig_prev_q;
  integer i;

  reg ram_we;
  reg [7:0] ram_addr;
  reg [7:0] ram_wdata;
  wire [7:0] ram_rdata_q;
  reg sfr_we;
  reg [7:0] sfr_wdata;
  reg [7:0] sfr_rd;
  reg stack_save;
  reg stack_restore;
  reg go_read;
  reg [7:0] pend_d;

  wire take = cmd_valid && cmd_ready_q;
  wire [7:0] stack_inc = stack_q + 8'h01;
  wire [7:0] stack_dec = stack_q - 8'h01;
  wire [7:0] bit_byte = bit_to_byte(cmd_addr);
  wire is_bit = (cmd_code == `CMD_BIT);
  wire [7:0] sfr_addr = is_bit ? bit_byte : cmd_addr;
  wire trig_edge = trig_prev_q && !timer2_external_trigger_pin;

  ////////////////////////////////////////////////////////////////////////////////
  // data ram, 256 bytes behind one port
  idata_ram #(
    .DEPTH(256),
    .AW(8)
  ) u_ram (
    .clock(clock),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata_q(ram_rdata_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sfr read mux
  always @* begin
    case (sfr_addr)
      `ADDR_PORT_ZERO_LATCH: sfr_rd = port_q[0];
      `ADDR_STACK_TOP_POINTER: sfr_rd = stack_q;
      `ADDR_DATA_POINTER_LOW_BYTE: sfr_rd = ptr_lo_q;
      `ADDR_DATA_POINTER_HIGH_BYTE: sfr_rd = ptr_hi_q;
      `ADDR_TIMER0_COUNT_LOW: sfr_rd = count_q[0][7:0];
      `ADDR_TIMER0_COUNT_HIGH: sfr_rd = count_q[0][15:8];
      `ADDR_TIMER1_COUNT_LOW: sfr_rd = count_q[1][7:0];
      `ADDR_TIMER1_COUNT_HIGH: sfr_rd = count_q[1][15:8];
      `ADDR_PORT_ONE_LATCH: sfr_rd = port_q[1];
      `ADDR_SERIAL_BUFFER: sfr_rd = rx_buffer_q;
      `ADDR_PORT_TWO_LATCH: sfr_rd = port_q[2];
      `ADDR_INTERRUPT_ENABLE_MASK: sfr_rd = irq_en_q;
      `ADDR_PORT_THREE_LATCH: sfr_rd = port_q[3];
      `ADDR_INTERRUPT_PRIORITY_SELECT: sfr_rd = irq_pri_q;
      `ADDR_CAPTURE_HIGH_REGISTER: sfr_rd = cap_hi_q;
      `ADDR_CAPTURE_LOW_REGISTER: sfr_rd = cap_lo_q;
      `ADDR_TIMER2_COUNT_LOW: sfr_rd = count_q[2][7:0];
      `ADDR_TIMER2_COUNT_HIGH: sfr_rd = count_q[2][15:8];
      `ADDR_STATUS_WORD: sfr_rd = status_q;
      `ADDR_MAIN_OPERAND_REGISTER: sfr_rd = main_q;
      `ADDR_MULTIPLY_DIVIDE_AUX_REGISTER: sfr_rd = aux_q;
      default: sfr_rd = `UNIMPLEMENTED_READ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  always @* begin
    state_d = state_q;
    ram_we = 1'b0;
    ram_addr = hold_addr_q;
    ram_wdata = cmd_wdata;
    sfr_we = 1'b0;
    sfr_wdata = cmd_wdata;
    stack_save = 1'b0;
    stack_restore = 1'b0;
    go_read = 1'b0;
    pend_d = pend_q;
    case (state_q)
      S_IDLE: begin
        if (take) begin
          case (cmd_code)
            `CMD_DIRECT: begin
              if (cmd_addr[7]) begin
                sfr_we = cmd_write;
                pend_d = sfr_rd;
                go_read = !cmd_write;
              end else begin
                ram_addr = cmd_addr;
                ram_we = cmd_write;
                go_read = !cmd_write;
              end
            end
            `CMD_INDIRECT: begin
              ram_addr = cmd_addr;
              ram_we = cmd_write;
              go_read = !cmd_write;
            end
            `CMD_BIT: begin
              if (bit_byte[7]) begin
                sfr_we = cmd_write;
                sfr_wdata = put_bit(sfr_rd, cmd_addr[2:0], cmd_wdata[0]);
                pend_d = sfr_rd;
                go_read = !cmd_write;
              end else begin
                ram_addr = bit_byte;
                go_read = 1'b1;
              end
            end
            `CMD_WORKING_REG: begin
              ram_addr = working_addr(status_q[`STATUS_BANK_HIGH_BIT:`STATUS_BANK_LOW_BIT], cmd_addr[2:0]);
              ram_we = cmd_write;
              go_read = !cmd_write;
            end
            `CMD_STACK_SAVE: begin
              ram_addr = stack_inc;
              ram_we = 1'b1;
              stack_save = 1'b1;
            end
            `CMD_STACK_RESTORE: begin
              ram_addr = stack_q;
              stack_restore = 1'b1;
              go_read = 1'b1;
            end
            default: begin
              go_read = 1'b0;
            end
          endcase
          if (go_read) begin
            state_d = S_READ;
          end
        end
      end
      S_READ: begin
        // ram bit write is read-modify-write: the byte is in the ram output now
        ram_addr = hold_addr_q;
        ram_wdata = put_bit(ram_rdata_q, bit_sel_q, bit_val_q);
        ram_we = bit_write_q && from_ram_q;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // access sequencing
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cmd_ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      from_ram_q <= 1'b0;
      bit_mode_q <= 1'b0;
      bit_write_q <= 1'b0;
      bit_val_q <= 1'b0;
      bit_sel_q <= 3'h0;
      hold_addr_q <= 8'h00;
      pend_q <= 8'h00;
      code_onchip_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_ready_q <= (state_d == S_IDLE);
      pend_q <= pend_d;
      rd_valid_q <= 1'b0;
      // program space is its own 16-bit space; only its low 8k may be local
      code_onchip_q <= HAS_ONCHIP_CODE && (prog_addr < `ONCHIP_CODE_BYTES);
      if (state_q == S_IDLE && take) begin
        hold_addr_q <= ram_addr;
        // sfr path only for direct upper half and bit addresses from 80h up
        from_ram_q <= !((cmd_code == `CMD_DIRECT && cmd_addr[7]) || (is_bit && bit_byte[7]));
        bit_mode_q <= is_bit;
        bit_write_q <= is_bit && cmd_write;
        bit_val_q <= cmd_wdata[0];
        bit_sel_q <= cmd_addr[2:0];
      end
      if (state_q == S_READ && !bit_write_q) begin
        rd_valid_q <= 1'b1;
        if (bit_mode_q) begin
          rd_data_q <= {7'h00, from_ram_q ? ram_rdata_q[bit_sel_q] : pend_q[bit_sel_q]};
        end else begin
          rd_data_q <= from_ram_q ? ram_rdata_q : pend_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // special function registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_q <= `RST_ZERO_BYTE;
      aux_q <= `RST_ZERO_BYTE;
      ptr_lo_q <= `RST_ZERO_BYTE;
      ptr_hi_q <= `RST_ZERO_BYTE;
      stack_q <= `RST_STACK_TOP_POINTER;
      status_q <= `RST_ZERO_BYTE;
      for (i = 0; i < 4; i = i + 1) begin
        port_q[i] <= `RST_PORT_LATCH;
      end
      irq_en_q <= `RST_INTERRUPT_ENABLE_MASK;
      irq_pri_q <= `RST_INTERRUPT_PRIORITY_SELECT;
      for (i = 0; i < 3; i = i + 1) begin
        count_q[i] <= 16'h0000;
      end
      cap_hi_q <= `RST_ZERO_BYTE;
      cap_lo_q <= `RST_ZERO_BYTE;
      trig_prev_q <= 1'b1;
      tx_data_q <= `RST_ZERO_BYTE;
      tx_start_q <= 1'b0;
      rx_buffer_q <= `RST_ZERO_BYTE;
    end else begin
      tx_start_q <= 1'b0;
      trig_prev_q <= timer2_external_trigger_pin;
      for (i = 0; i < 3; i = i + 1) begin
        if (timer_tick[i]) begin
          if (i == 2 && t2_reload_mode && count_q[2] == `TIMER_COUNT_MAX) begin
            count_q[2] <= {cap_hi_q, cap_lo_q};
          end else begin
            count_q[i] <= count_q[i] + 16'h0001;
          end
        end
      end
      if (stack_save) begin
        stack_q <= stack_inc;
      end else if (stack_restore) begin
        stack_q <= stack_dec;
      end
      if (sfr_we) begin
        case (sfr_addr)
          `ADDR_PORT_ZERO_LATCH: port_q[0] <= sfr_wdata;
          `ADDR_STACK_TOP_POINTER: stack_q <= sfr_wdata;
          `ADDR_DATA_POINTER_LOW_BYTE: ptr_lo_q <= sfr_wdata;
          `ADDR_DATA_POINTER_HIGH_BYTE: ptr_hi_q <= sfr_wdata;
          `ADDR_TIMER0_COUNT_LOW: count_q[0][7:0] <= sfr_wdata;
          `ADDR_TIMER0_COUNT_HIGH: count_q[0][15:8] <= sfr_wdata;
          `ADDR_TIMER1_COUNT_LOW: count_q[1][7:0] <= sfr_wdata;
          `ADDR_TIMER1_COUNT_HIGH: count_q[1][15:8] <= sfr_wdata;
          `ADDR_PORT_ONE_LATCH: port_q[1] <= sfr_wdata;
          `ADDR_SERIAL_BUFFER: begin
            tx_data_q <= sfr_wdata;
            tx_start_q <= 1'b1;
          end
          `ADDR_PORT_TWO_LATCH: port_q[2] <= sfr_wdata;
          `ADDR_INTERRUPT_ENABLE_MASK: irq_en_q <= sfr_wdata;
          `ADDR_PORT_THREE_LATCH: port_q[3] <= sfr_wdata;
          `ADDR_INTERRUPT_PRIORITY_SELECT: irq_pri_q <= sfr_wdata;
          `ADDR_CAPTURE_HIGH_REGISTER: cap_hi_q <= sfr_wdata;
          `ADDR_CAPTURE_LOW_REGISTER: cap_lo_q <= sfr_wdata;
          `ADDR_TIMER2_COUNT_LOW: count_q[2][7:0] <= sfr_wdata;
          `ADDR_TIMER2_COUNT_HIGH: count_q[2][15:8] <= sfr_wdata;
          `ADDR_STATUS_WORD: status_q <= sfr_wdata;
          `ADDR_MAIN_OPERAND_REGISTER: main_q <= sfr_wdata;
          `ADDR_MULTIPLY_DIVIDE_AUX_REGISTER: aux_q <= sfr_wdata;
          default: status_q <= status_q;
        endcase
      end
      // core results beat a register write in the same cycle
      if (md_we) begin
        main_q <= md_main_wdata;
        aux_q <= md_aux_wdata;
      end
      if (data_pointer_we) begin
        ptr_hi_q <= data_pointer_wdata[15:8];
        ptr_lo_q <= data_pointer_wdata[7:0];
      end
      if (rx_load) begin
        rx_buffer_q <= rx_data;
      end
      // capture is a hardware event, so it wins over a software write
      if (t2_capture_mode && trig_edge) begin
        cap_hi_q <= count_q[2][15:8];
        cap_lo_q <= count_q[2][7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cmd_ready = cmd_ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign code_onchip = code_onchip_q;
  assign tx_data = tx_data_q;
  assign tx_start = tx_start_q;
  assign main_operand = main_q;
  assign aux_operand = aux_q;
  assign data_pointer = {ptr_hi_q, ptr_lo_q};
  assign stack_top_pointer = stack_q;
  assign bank_select = status_q[`STATUS_BANK_HIGH_BIT:`STATUS_BANK_LOW_BIT];
  assign port_zero_latch = port_q[0];
  assign port_one_latch = port_q[1];
  assign port_two_latch = port_q[2];
  assign port_three_latch = port_q[3];
  assign interrupt_enable_mask = irq_en_q;
  assign interrupt_priority_select = irq_pri_q;
  assign timer0_count = count_q[0];
  assign timer1_count = count_q[1];
  assign timer2_count = count_q[2];
  assign capture_value = {cap_hi_q, cap_lo_q};

endmodule // idata_sfr_map

// ===== verif/idata_sfr_map_checker.sv
`timescale 1ns/100ps
module idata_sfr_map_checker #(
  parameter HAS_ONCHIP_CODE = 1'b1
) (
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire cmd_write,
  input wire [7:0] cmd_addr,
  input wire [7:0] cmd_wdata,
  input wire cmd_ready,
  input wire rd_valid,
  input wire md_we,
  input wire [7:0] md_main_wdata,
  input wire [7:0] md_aux_wdata,
  input wire data_pointer_we,
  input wire [15:0] data_pointer_wdata,
  input wire [15:0] prog_addr,
  input wire code_onchip,
  input wire [7:0] tx_data,
  input wire tx_start,
  input wire [7:0] main_operand,
  input wire [7:0] aux_operand,
  input wire [15:0] data_pointer,
  input wire [7:0] stack_top_pointer,
  input wire [1:0] bank_select
);
  wire take = cmd_valid && cmd_ready;
  wire dwr = take && cmd_code == 3'h0 && cmd_write;
  wire [1:0] wbank = cmd_wdata[4:3];
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a read stalls the port one cycle, then answers
  sequence s_read_wait;
    !cmd_ready ##[1:2] rd_valid;
  endsequence
  sequence s_tx_pulse;
    tx_start && tx_data == $past(cmd_wdata) ##1 !tx_start;
  endsequence
  a_read_answer: assert property (take && cmd_code == 3'h0 && !cmd_write |=> s_read_wait)
    else $error("direct read not answered in time");
  a_stack_reset: assert property ($rose(rst_n) |-> stack_top_pointer == 8'h07)
    else $error("stack pointer not 07 after reset");
  a_bank_reset: assert property ($rose(rst_n) |-> bank_select == 2'h0)
    else $error("bank not 0 after reset");
  a_push_pre_inc: assert property (take && cmd_code == 3'h4 |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("stack save did not step pointer up");
  a_pop_step_down: assert property (take && cmd_code == 3'h5 |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("stack restore did not step pointer down");
  a_code_window: assert property ($past(rst_n) |-> code_onchip == (HAS_ONCHIP_CODE && $past(prog_addr) < 16'h2000))
    else $error("on-chip code flag wrong");
  a_serial_start: assert property (dwr && cmd_addr == 8'h99 |=> s_tx_pulse)
    else $error("serial write did not start one pulse");
  a_muldiv_load: assert property (md_we |=> main_operand == $past(md_main_wdata) && aux_operand == $past(md_aux_wdata))
    else $error("operand load lost");
  a_bank_write: assert property (dwr && cmd_addr == 8'hd0 |=> bank_select == $past(wbank))
    else $error("bank select not taken from status write");
  a_pointer_load: assert property (data_pointer_we |=> data_pointer == $past(data_pointer_wdata))
    else $error("data pointer 16 bit load lost");
endmodule // idata_sfr_map_checker
bind idata_sfr_map idata_sfr_map_checker #(.HAS_ONCHIP_CODE(HAS_ONCHIP_CODE)) u_idata_sfr_map_checker (
  .clock, .rst_n, .cmd_valid, .cmd_code, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rd_valid, .md_we,
  .md_main_wdata, .md_aux_wdata, .data_pointer_we, .data_pointer_wdata, .prog_addr, .code_onchip, .tx_data,
  .tx_start, .main_operand, .aux_operand, .data_pointer, .stack_top_pointer, .bank_select);

// ===== verif/core_access_model.sv
`timescale 1ns/100ps
module core_access_model (
  input wire clock,
  output reg cmd_valid,
  output reg [2:0] cmd_code,
  output reg cmd_write,
  output reg [7:0] cmd_addr,
  output reg [7:0] cmd_wdata,
  input wire cmd_ready,
  input wire rd_valid,
  input wire [7:0] rd_data
);
  reg hung;
  initial begin
    {cmd_valid, cmd_code, cmd_write, cmd_addr, cmd_wdata} = 21'h0;
    hung = 1'b0;
  end
  // held until ready seen at an edge; released lines inverted so stale data never matches
  task xfer(input [2:0] c, input w, input [7:0] a, input [7:0] d, output [7:0] q);
    integer n;
    begin
      q = 8'h00;
      @(posedge clock);
      {cmd_valid, cmd_code, cmd_write, cmd_addr, cmd_wdata} <= {1'b1, c, w, a, d};
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (!cmd_ready && n < 20);
      hung = hung | !cmd_ready;
      {cmd_valid, cmd_addr, cmd_wdata} <= {1'b0, ~a, ~d};
      if (c == 3'h5 || (c < 3'h4 && !w)) begin
        n = 0;
        do begin
          @(posedge clock);
          n = n + 1;
        end while (!rd_valid && n < 20);
        hung = hung | !rd_valid;
        q = rd_data;
      end
    end
  endtask
endmodule // core_access_model

// ===== verif/tb_idata_sfr_map.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin err_count = err_count + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_idata_sfr_map;
  reg clock, rst_n, md_we, data_pointer_we, t2_capture_mode, t2_reload_mode, timer2_external_trigger_pin, rx_load;
  reg [7:0] md_main_wdata, md_aux_wdata, rx_data, q;
  reg [15:0] data_pointer_wdata, prog_addr;
  reg [2:0] timer_tick;
  wire cmd_valid, cmd_write, cmd_ready, rd_valid, code_onchip, tx_start;
  wire [2:0] cmd_code;
  wire [1:0] bank_select;
  wire [7:0] cmd_addr, cmd_wdata, rd_data, tx_data, main_operand, aux_operand, stack_top_pointer;
  wire [7:0] port_zero_latch, port_one_latch, port_two_latch, port_three_latch;
  wire [7:0] interrupt_enable_mask, interrupt_priority_select;
  wire [15:0] data_pointer, timer0_count, timer1_count, timer2_count, capture_value;
  integer err_count, tests_run, i;
  localparam [159:0] RV = {16'h80ff, 16'h8107, 16'h8200, 16'h8300, 16'h90ff, 16'ha0ff, 16'ha800, 16'hb800,
    16'he000, 16'hf000};
  idata_sfr_map u_idata_sfr_map (.clock, .rst_n, .cmd_valid, .cmd_code, .cmd_write, .cmd_addr, .cmd_wdata,
    .cmd_ready, .rd_valid, .rd_data, .md_we, .md_main_wdata, .md_aux_wdata, .data_pointer_we,
    .data_pointer_wdata, .prog_addr, .code_onchip, .timer_tick, .t2_capture_mode, .t2_reload_mode,
    .timer2_external_trigger_pin, .rx_load,
    .rx_data, .tx_data, .tx_start, .main_operand, .aux_operand, .data_pointer, .stack_top_pointer, .bank_select,
    .port_zero_latch, .port_one_latch, .port_two_latch, .port_three_latch, .interrupt_enable_mask,
    .interrupt_priority_select, .timer0_count, .timer1_count, .timer2_count, .capture_value);
  core_access_model u_core_access_model (.clock, .cmd_valid, .cmd_code, .cmd_write, .cmd_addr, .cmd_wdata,
    .cmd_ready, .rd_valid, .rd_data);
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    begin
      $display("counts: run=%0d failed=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // returns at the negedge after the take, or after rd_valid for a read, so outputs have settled
  task go(input [2:0] c, input w, input [7:0] a, input [7:0] d);
    begin
      u_core_access_model.xfer(c, w, a, d, q);
      @(negedge clock);
      if (u_core_access_model.hung) begin
        err_count = err_count + 1;
        print_verdict;
      end
    end
  endtask
  task wd(input [7:0] a, input [7:0] d);
    go(3'h0, 1'b1, a, d);
  endtask
  task rdc(input [2:0] c, input [7:0] a, input [7:0] e);
    begin
      go(c, 1'b0, a, 8'h00);
      `CHK(q, e)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      `CHK(bank_select, 2'h0)
      `CHK({interrupt_enable_mask, interrupt_priority_select}, 16'h0000)
      for (i = 0; i < 10; i = i + 1) rdc(3'h0, RV[i*16+8 +: 8], RV[i*16 +: 8]);
      $display("test reset values done");
    end
  endtask
  task t_stack;
    begin
      go(3'h4, 1'b1, 8'h00, 8'ha1);
      `CHK(stack_top_pointer, 8'h08)
      rdc(3'h0, 8'h08, 8'ha1);
      wd(8'h81, 8'hc0);
      go(3'h4, 1'b1, 8'h00, 8'h77);
      rdc(3'h1, 8'hc1, 8'h77);
      rdc(3'h5, 8'h00, 8'h77);
      `CHK(stack_top_pointer, 8'hc0)
      $display("test stack done");
    end
  endtask
  task t_space;
    begin
      wd(8'h90, 8'h3c);
      wd(8'h80, 8'h11);
      wd(8'ha0, 8'h22);
      wd(8'hb0, 8'h33);
      `CHK({port_zero_latch, port_one_latch, port_two_latch, port_three_latch}, 32'h113c2233)
      go(3'h1, 1'b1, 8'h90, 8'h5a);
      rdc(3'h0, 8'h90, 8'h3c);
      rdc(3'h1, 8'h90, 8'h5a);
      wd(8'h45, 8'ha5);
      rdc(3'h1, 8'h45, 8'ha5);
      go(3'h1, 1'b1, 8'hc1, 8'h99);
      wd(8'hc1, 8'h00);
      rdc(3'h0, 8'hc1, 8'h00);
      rdc(3'h1, 8'hc1, 8'h99);
      $display("test address spaces done");
    end
  endtask
  task t_ptr_ops;
    begin
      wd(8'h82, 8'h34);
      wd(8'h83, 8'h12);
      `CHK(data_pointer, 16'h1234)
      @(posedge clock);
      {data_pointer_wdata, md_main_wdata, md_aux_wdata} <= 32'hbeef3cc3;
      {data_pointer_we, md_we} <= 2'b11;
      @(posedge clock);
      {data_pointer_we, md_we} <= 2'b00;
      rdc(3'h0, 8'h82, 8'hef);
      rdc(3'h0, 8'h83, 8'hbe);
      rdc(3'h0, 8'he0, 8'h3c);
      rdc(3'h0, 8'hf0, 8'hc3);
      wd(8'hf0, 8'h55);
      rdc(3'h0, 8'hf0, 8'h55);
      $display("test pointer and operands done");
    end
  endtask
  task t_banks_bits;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wd(8'hd0, {3'h0, i[1:0], 3'h0});
        `CHK(bank_select, i[1:0])
        go(3'h3, 1'b1, 8'h05, {6'h18, i[1:0]});
        rdc(3'h0, {3'h0, i[1:0], 3'h5}, {6'h18, i[1:0]});
      end
      wd(8'h21, 8'h00);
      wd(8'h2f, 8'h00);
      go(3'h2, 1'b1, 8'h0b, 8'h01);
      go(3'h2, 1'b1, 8'h7f, 8'h01);
      rdc(3'h0, 8'h21, 8'h08);
      rdc(3'h0, 8'h2f, 8'h80);
      rdc(3'h2, 8'h0b, 8'h01);
      go(3'h2, 1'b1, 8'h81, 8'h01);
      `CHK(port_zero_latch, 8'h13)
      rdc(3'h2, 8'h84, 8'h01);
      $display("test banks and bits done");
    end
  endtask
  task t_serial;
    begin
      wd(8'h99, 8'ha7);
      `CHK({tx_start, tx_data}, 9'h1a7)
      @(negedge clock);
      `CHK(tx_start, 1'b0)
      @(posedge clock);
      {rx_load, rx_data} <= 9'h13e;
      @(posedge clock);
      rx_load <= 1'b0;
      rdc(3'h0, 8'h99, 8'h3e);
      $display("test serial buffer done");
    end
  endtask
  task t_timers;
    begin
      @(posedge clock);
      timer_tick <= 3'h1;
      repeat (5) @(posedge clock);
      timer_tick <= 3'h0;
      rdc(3'h0, 8'h8a, 8'h05);
      `CHK(timer0_count, 16'h0005)
      `CHK(timer1_count, 16'h0000)
      wd(8'hcc, 8'h34);
      wd(8'hcd, 8'h12);
      @(posedge clock);
      t2_capture_mode <= 1'b1;
      @(posedge clock);
      timer2_external_trigger_pin <= 1'b0;
      repeat (3) @(posedge clock);
      {t2_capture_mode, timer2_external_trigger_pin} <= 2'b01;
      @(negedge clock);
      `CHK(capture_value, 16'h1234)
      wd(8'hca, 8'hab);
      wd(8'hcb, 8'hcd);
      wd(8'hcc, 8'hff);
      wd(8'hcd, 8'hff);
      @(posedge clock);
      {t2_reload_mode, timer_tick} <= 4'hc;
      @(posedge clock);
      {t2_reload_mode, timer_tick} <= 4'h0;
      @(negedge clock);
      `CHK(timer2_count, 16'habcd)
      $display("test timers done");
    end
  endtask
  task t_code;
    begin
      @(posedge clock);
      prog_addr <= 16'h1fff;
      repeat (2) @(negedge clock);
      `CHK(code_onchip, 1'b1)
      @(posedge clock);
      prog_addr <= 16'h2000;
      repeat (2) @(negedge clock);
      `CHK(code_onchip, 1'b0)
      $display("test code space done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock, rst_n, md_we, data_pointer_we, t2_capture_mode, t2_reload_mode, rx_load} = 7'h00;
    timer2_external_trigger_pin = 1'b1;
    {md_main_wdata, md_aux_wdata, rx_data, data_pointer_wdata, prog_addr, timer_tick} = 59'h0;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_stack;
    t_space;
    t_ptr_ops;
    t_banks_bits;
    t_serial;
    t_timers;
    t_code;
    print_verdict;
  end
endmodule // tb_idata_sfr_map
